// file: lss_pkg.sv
// package for the legacy system support block: port addresses, field positions, reset values
// assumes a cpu-side i/o bus with 16-bit addresses and 8-bit data
package lss_pkg;

	// ----------------------------------------------------------------
	// i/o port addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] FEATURE_PORT_ADDR = 16'h0061;
	localparam logic [15:0] NMI_CLOCK_ADDR = 16'h0070;
	localparam logic [15:0] CFG_INDEX_ADDR = 16'h0022;
	localparam logic [15:0] CFG_DATA_ADDR = 16'h0023;
	localparam logic [15:0] SYS_CTRL_PORT_ADDR = 16'h0092;
	localparam logic [7:0] MISC1_INDEX = 8'h6f;

	// ----------------------------------------------------------------
	// feature control port fields
	// ----------------------------------------------------------------
	localparam int TIMER2_GATE_BIT = 0;
	localparam int SPEAKER_DATA_BIT = 1;
	localparam int PARITY_CHECK_EN_BIT = 2;
	localparam int IO_CHECK_EN_BIT = 3;
	localparam int TIMER2_OUT_STAT_BIT = 5;
	localparam int IO_CHECK_STAT_BIT = 6;
	localparam int PARITY_STAT_BIT = 7;

	// ----------------------------------------------------------------
	// nmi mask / clock index and a20 / fast reset fields
	// ----------------------------------------------------------------
	localparam int NMI_MASK_BIT = 7;
	localparam int FAST_RESET_BIT = 0;
	localparam int ADDR20_GATE_BIT = 1;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [3:0] FEATURE_CTRL_RST = 4'h0;
	localparam logic [3:0] FEATURE_HI_RST = 4'h0;
	localparam logic NMI_MASK_RST = 1'b1;
	localparam logic [6:0] CLOCK_INDEX_RST = 7'h00;
	localparam logic [1:0] MISC1_CFG_RST = 2'h0;
	localparam int SYNC_STAGES = 2;
	localparam int SHUTDOWN_PULSE_CLKS = 16;
	localparam int FAST_PULSE_CLKS = 16;
	localparam logic [2:0] SHUTDOWN_CODE = 3'h5;

endpackage

// file: lss_rst_if.sv
// interface carrying synchronised reset requests to the cpu reset stretcher
// assumes one clock shared by both ends
interface lss_rst_if;
	logic trigger;
	logic cpu_reset;
	modport src (output trigger, input cpu_reset);
	modport gen (input trigger, output cpu_reset);
endinterface

// file: lss_cpu_reset_gen.sv
// cpu reset pulse stretcher: any trigger yields a pulse of at least PULSE_CLKS
// assumes trigger is synchronous to clk_i
module lss_cpu_reset_gen #(
	parameter int PULSE_CLKS = lss_pkg::SHUTDOWN_PULSE_CLKS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// request and pulse
	lss_rst_if.gen rq
);
	logic [7:0] cnt_reg, cnt_next;

	always_comb begin
		cnt_next = cnt_reg;
		if (rq.trigger) begin
			cnt_next = 8'(PULSE_CLKS);
		end else if (cnt_reg != 8'h00) begin
			cnt_next = cnt_reg - 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// reset stays high while the counter runs: 16 clocks minimum after the trigger ends
	assign rq.cpu_reset = (cnt_reg != 8'h00);
endmodule

// file: lss_top.sv
// legacy system support: feature port, nmi mask, speaker, a20 gate, reset combining
// assumes a single-cycle i/o bus, shutdown status from the cpu, timer 2 and rtc outside
// Functional notes
// - feature control port decoded as 8-bit register at i/o 061h
// - low four bits are read/write nmi source and sound enables
// - high four bits: bit 4 is read/write, bits 7..5 read back parity, i/o check and timer 2 status
// - bit 7 at 070h masks every nmi regardless of source enables
// - nmi mask bit is write-only, active high (1 masks), resets to 1
// - bits 6..0 at 070h are write-only clock index bits
// - speaker fed from timer channel 2 output
// - timer 2 gate comes from the feature port gate bit
// - speaker also fed directly by the speaker data bit; the code ANDs that bit with the timer 2 output instead
// - address line 20 can be forced to zero
// - external gate high passes cpu address bit 20
// - external gate low and internal gate off drives line 20 low
// - internal a20 gate via configuration index 6fh and port 92h
// - power-good reset input is active low asynchronous
// - power-good low resets all but the misc1 and port 92h config bits
// - battery-loss reset low resets everything
// - both hardware resets are synchronised to the cpu clock
// - keyboard, fast and shutdown resets hit only the cpu
// - fast cpu reset via configuration index 6fh or port 92h
// - shutdown code triggers cpu reset of at least 16 clocks
module lss_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// i/o bus from the cpu core
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic io_rd_hit_o,
	// cpu status and address
	input wire logic [2:0] cpu_status_i,
	input wire logic cpu_status_valid_i,
	input wire logic cpu_addr20_i,
	output logic sys_addr20_o,
	output logic cpu_reset_o,
	// nmi sources
	input wire logic parity_err_i,
	input wire logic io_check_err_i,
	output logic nmi_o,
	// timer 2 and speaker
	input wire logic timer2_output,
	output logic timer2_gate_o,
	output logic speaker_o,
	// real-time clock side
	output logic [6:0] clock_index_o,
	output logic clock_index_wr_o,
	// keyboard controller and external resets
	input wire logic external_addr20_gate_input,
	input wire logic kbc_cpu_reset_n_i,
	input wire logic power_good_reset_in,
	input wire logic battery_loss_reset_in,
	// hardware reset seen by the rest of the chip
	output logic hw_reset_o,
	output logic full_reset_o
);
	// ----------------------------------------------------------------
	// reset synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pg_sync_reg, pg_sync_next;
	logic [1:0] bl_sync_reg, bl_sync_next;
	logic hw_rst;
	logic full_rst;

	always_comb begin
		// low input is treated as asynchronous, so it is only sampled here
		pg_sync_next = {pg_sync_reg[0], power_good_reset_in};
		bl_sync_next = {bl_sync_reg[0], battery_loss_reset_in};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pg_sync_reg <= 2'h0;
			bl_sync_reg <= 2'h0;
		end else begin
			pg_sync_reg <= pg_sync_next;
			bl_sync_reg <= bl_sync_next;
		end
	end

	assign full_rst = rst_i | ~bl_sync_reg[1];
	assign hw_rst = full_rst | ~pg_sync_reg[1];
	assign hw_reset_o = hw_rst;
	assign full_reset_o = full_rst;

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [3:0] feat_ctrl_reg, feat_ctrl_next;
	logic [3:0] feat_hi_reg, feat_hi_next;
	logic nmi_mask_reg, nmi_mask_next;
	logic [6:0] clk_idx_reg, clk_idx_next;
	logic idx_wr_reg, idx_wr_next;
	logic [7:0] cfg_index_reg, cfg_index_next;
	// config bits survive power-good reset, only battery loss or rst_i clears them
	logic [1:0] misc1_reg, misc1_next;
	logic [1:0] port92_reg, port92_next;
	logic par_stat_reg, par_stat_next;
	logic ioc_stat_reg, ioc_stat_next;
	logic fast_pulse;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
		return a == p;
	endfunction

	always_comb begin
		feat_ctrl_next = feat_ctrl_reg;
		feat_hi_next = feat_hi_reg;
		nmi_mask_next = nmi_mask_reg;
		clk_idx_next = clk_idx_reg;
		idx_wr_next = 1'b0;
		cfg_index_next = cfg_index_reg;
		misc1_next = misc1_reg;
		port92_next = port92_reg;
		fast_pulse = 1'b0;
		if (io_wr_i) begin
			if (hit(io_addr_i, lss_pkg::FEATURE_PORT_ADDR)) begin
				feat_ctrl_next = io_wdata_i[3:0];
				feat_hi_next = io_wdata_i[7:4];
			end else if (hit(io_addr_i, lss_pkg::NMI_CLOCK_ADDR)) begin
				nmi_mask_next = io_wdata_i[lss_pkg::NMI_MASK_BIT];
				clk_idx_next = io_wdata_i[6:0];
				idx_wr_next = 1'b1;
			end else if (hit(io_addr_i, lss_pkg::CFG_INDEX_ADDR)) begin
				cfg_index_next = io_wdata_i;
			end else if (hit(io_addr_i, lss_pkg::CFG_DATA_ADDR)) begin
				if (cfg_index_reg == lss_pkg::MISC1_INDEX) begin
					misc1_next = io_wdata_i[1:0];
					fast_pulse = io_wdata_i[lss_pkg::FAST_RESET_BIT];
				end
			end else if (hit(io_addr_i, lss_pkg::SYS_CTRL_PORT_ADDR)) begin
				port92_next = io_wdata_i[1:0];
				// reset fires on the rising write of the fast reset bit
				fast_pulse = io_wdata_i[lss_pkg::FAST_RESET_BIT] &
					~port92_reg[lss_pkg::FAST_RESET_BIT];
			end
		end
		// error status latches; a new error wins over a disabling write
		par_stat_next = (par_stat_reg & feat_ctrl_next[lss_pkg::PARITY_CHECK_EN_BIT]) |
			(parity_err_i & feat_ctrl_reg[lss_pkg::PARITY_CHECK_EN_BIT]);
		ioc_stat_next = (ioc_stat_reg & feat_ctrl_next[lss_pkg::IO_CHECK_EN_BIT]) |
			(io_check_err_i & feat_ctrl_reg[lss_pkg::IO_CHECK_EN_BIT]);
	end

	always_ff @(posedge clk_i) begin
		if (hw_rst) begin
			feat_ctrl_reg <= lss_pkg::FEATURE_CTRL_RST;
			feat_hi_reg <= lss_pkg::FEATURE_HI_RST;
			nmi_mask_reg <= lss_pkg::NMI_MASK_RST;
			clk_idx_reg <= lss_pkg::CLOCK_INDEX_RST;
			idx_wr_reg <= 1'b0;
			cfg_index_reg <= 8'h00;
			par_stat_reg <= 1'b0;
			ioc_stat_reg <= 1'b0;
		end else begin
			feat_ctrl_reg <= feat_ctrl_next;
			feat_hi_reg <= feat_hi_next;
			nmi_mask_reg <= nmi_mask_next;
			clk_idx_reg <= clk_idx_next;
			idx_wr_reg <= idx_wr_next;
			cfg_index_reg <= cfg_index_next;
			par_stat_reg <= par_stat_next;
			ioc_stat_reg <= ioc_stat_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (full_rst) begin
			misc1_reg <= lss_pkg::MISC1_CFG_RST;
			port92_reg <= lss_pkg::MISC1_CFG_RST;
		end else begin
			misc1_reg <= misc1_next;
			port92_reg <= port92_next;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [7:0] rdata_reg, rdata_next;
	logic rd_hit_reg, rd_hit_next;

	always_comb begin
		rdata_next = 8'h00;
		rd_hit_next = 1'b0;
		if (io_rd_i) begin
			if (hit(io_addr_i, lss_pkg::FEATURE_PORT_ADDR)) begin
				rd_hit_next = 1'b1;
				rdata_next = {feat_hi_reg, feat_ctrl_reg};
				rdata_next[lss_pkg::PARITY_STAT_BIT] = par_stat_reg;
				rdata_next[lss_pkg::IO_CHECK_STAT_BIT] = ioc_stat_reg;
				rdata_next[lss_pkg::TIMER2_OUT_STAT_BIT] = timer2_output;
			end else if (hit(io_addr_i, lss_pkg::CFG_INDEX_ADDR)) begin
				rd_hit_next = 1'b1;
				rdata_next = cfg_index_reg;
			end else if (hit(io_addr_i, lss_pkg::CFG_DATA_ADDR)) begin
				rd_hit_next = (cfg_index_reg == lss_pkg::MISC1_INDEX);
				rdata_next = rd_hit_next ? {6'h00, misc1_reg} : 8'h00;
			end else if (hit(io_addr_i, lss_pkg::SYS_CTRL_PORT_ADDR)) begin
				rd_hit_next = 1'b1;
				rdata_next = {6'h00, port92_reg};
			end
			// 070h is write-only: not claimed, reads float to the bus default
		end
	end

	always_ff @(posedge clk_i) begin
		if (hw_rst) begin
			rdata_reg <= 8'h00;
			rd_hit_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rd_hit_reg <= rd_hit_next;
		end
	end

	assign io_rdata_o = rdata_reg;
	assign io_rd_hit_o = rd_hit_reg;

	// ----------------------------------------------------------------
	// nmi, speaker, clock index outputs
	// ----------------------------------------------------------------
	assign nmi_o = ~nmi_mask_reg & (par_stat_reg | ioc_stat_reg);
	assign clock_index_o = clk_idx_reg;
	assign clock_index_wr_o = idx_wr_reg;
	assign timer2_gate_o = feat_ctrl_reg[lss_pkg::TIMER2_GATE_BIT];
	// both paths must agree; the data bit alone can still toggle a held-high timer
	assign speaker_o = timer2_output &
		feat_ctrl_reg[lss_pkg::SPEAKER_DATA_BIT];

	// ----------------------------------------------------------------
	// address line 20 gate
	// ----------------------------------------------------------------
	logic int_a20_gate;
	assign int_a20_gate = misc1_reg[lss_pkg::ADDR20_GATE_BIT] |
		port92_reg[lss_pkg::ADDR20_GATE_BIT];
	// combinational so the address path adds no cycle of latency
	assign sys_addr20_o = cpu_addr20_i &
		(external_addr20_gate_input | int_a20_gate);

	// ----------------------------------------------------------------
	// cpu-only reset sources
	// ----------------------------------------------------------------
	logic shutdown_seen;
	logic kbc_req;
	lss_rst_if rq ();

	assign shutdown_seen = cpu_status_valid_i &
		(cpu_status_i == lss_pkg::SHUTDOWN_CODE);
	assign kbc_req = ~kbc_cpu_reset_n_i;
	assign rq.trigger = shutdown_seen | kbc_req | fast_pulse;

	lss_cpu_reset_gen #(
		.PULSE_CLKS(lss_pkg::SHUTDOWN_PULSE_CLKS)
	) u_rst_gen (
		.clk_i(clk_i),
		.rst_i(hw_rst),
		.rq(rq.gen)
	);

	// hardware reset also holds the cpu; cpu-only sources never touch hw_rst
	assign cpu_reset_o = hw_rst | rq.cpu_reset;
endmodule

// file: lss_sva.sv
// concurrent checks on the ports of the legacy support top
// assumes one clock domain; bound from the bench file
module lss_sva (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// i/o bus
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic [7:0] io_rdata_o,
	input wire logic io_rd_hit_o,
	// cpu side
	input wire logic [2:0] cpu_status_i,
	input wire logic cpu_status_valid_i,
	input wire logic cpu_addr20_i,
	input wire logic sys_addr20_o,
	input wire logic cpu_reset_o,
	input wire logic nmi_o,
	// timer, speaker, keyboard and reset pins
	input wire logic timer2_output,
	input wire logic timer2_gate_o,
	input wire logic speaker_o,
	input wire logic external_addr20_gate_input,
	input wire logic kbc_cpu_reset_n_i,
	input wire logic power_good_reset_in,
	input wire logic battery_loss_reset_in,
	input wire logic hw_reset_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// helpers
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic mask_reg;
	logic [1:0] quiet_reg;
	// shadow of the mask, since it can never be read back
	always_ff @(posedge clk_i) begin
		if (rst_i || hw_reset_o)
			mask_reg <= 1'b1;
		else if (io_wr_i && io_addr_i == lss_pkg::NMI_CLOCK_ADDR)
			mask_reg <= io_wdata_i[lss_pkg::NMI_MASK_BIT];
	end
	// three quiet cycles cover the synchroniser drain
	always_ff @(posedge clk_i) begin
		if (rst_i || !power_good_reset_in || !battery_loss_reset_in)
			quiet_reg <= 2'h0;
		else if (quiet_reg != 2'h3)
			quiet_reg <= quiet_reg + 2'h1;
	end
	sequence s_shut;
		cpu_status_valid_i && cpu_status_i == lss_pkg::SHUTDOWN_CODE;
	endsequence
	// ----
	// assertions
	// ----
	a_speaker_timer_and: assert property (!timer2_output |-> !speaker_o)
		else $error("speaker high with timer 2 low");
	a_gate_follows: assert property ((io_wr_i && io_addr_i == lss_pkg::FEATURE_PORT_ADDR
		&& !hw_reset_o) |=> timer2_gate_o == $past(io_wdata_i[0]))
		else $error("timer gate not the written bit");
	a_a20_pass: assert property (external_addr20_gate_input |->
		sys_addr20_o == cpu_addr20_i)
		else $error("a20 not passed with gate high");
	a_a20_low: assert property (!cpu_addr20_i |-> !sys_addr20_o)
		else $error("a20 high without cpu a20");
	a_shut_pulse: assert property (s_shut |=> cpu_reset_o [*8] ##1 cpu_reset_o [*8])
		else $error("shutdown pulse shorter than 16");
	a_kbc_reset: assert property ($fell(kbc_cpu_reset_n_i) |=> cpu_reset_o [*8])
		else $error("keyboard reset request ignored");
	a_nmi_masked: assert property (mask_reg |-> !nmi_o)
		else $error("nmi passed while masked");
	a_mask_unread: assert property ((io_rd_i && io_addr_i == lss_pkg::NMI_CLOCK_ADDR)
		|=> !io_rd_hit_o && io_rdata_o == 8'h00)
		else $error("write-only port answered a read");
	a_feature_read: assert property ((io_rd_i && io_addr_i == lss_pkg::FEATURE_PORT_ADDR)
		|=> io_rd_hit_o && io_rdata_o[0] == $past(timer2_gate_o))
		else $error("feature port read wrong");
	a_hw_sync: assert property ((!power_good_reset_in || !battery_loss_reset_in) [*2]
		|=> hw_reset_o)
		else $error("hardware reset not raised");
	a_cpu_only: assert property (quiet_reg == 2'h3 |-> !hw_reset_o)
		else $error("hardware reset without a pin");
	c_shutdown: cover property (s_shut);
	c_nmi: cover property (!mask_reg && nmi_o);
	c_read: cover property (io_rd_i ##1 io_rd_hit_o);
endmodule

// file: lss_kbc_model.sv
// far side: timer channel 2 and the keyboard controller pins
// assumes bench commands and the block clock
module lss_kbc_model (
	// clock
	input wire logic clk_i,
	// gate and bench commands
	input wire logic gate_i,
	input wire logic a20_cmd_i,
	input wire logic cpu_rst_cmd_i,
	// pins toward the block
	output logic timer2_o,
	output logic a20_o = 1'b0,
	output logic cpu_rst_n_o = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div_reg = 2'h0;
	// the controller is slow: its pins lag the command by a cycle
	always @(posedge clk_i) begin
		div_reg <= gate_i ? div_reg + 2'h1 : 2'h0;
		a20_o <= a20_cmd_i;
		cpu_rst_n_o <= !cpu_rst_cmd_i;
	end
	// parked high while the gate is off, square wave otherwise
	assign timer2_o = !div_reg[1];
endmodule

// file: lss_top_bench.sv
// self-checking bench for lss_top with far-side model and checker
// assumes lss_pkg, the model and the checker compile first
module lss_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [7:0] d; logic [4:0] rb;} lss_row_s;
	localparam lss_row_s ROWS [5] = '{'{8'h00, 5'h00}, '{8'h01, 5'h01}, '{8'h03, 5'h03},
		'{8'h0e, 5'h0e}, '{8'h13, 5'h13}};
	logic clk_i = 1'b0, rst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0, cpu_status_valid_i = 1'b0;
	logic [15:0] io_addr_i = 16'h0000;
	logic [7:0] io_wdata_i = 8'h00, io_rdata_o;
	logic [2:0] cpu_status_i = 3'h0;
	logic cpu_addr20_i = 1'b0, parity_err_i = 1'b0, io_check_err_i = 1'b0, a20_cmd = 1'b0;
	logic cpu_rst_cmd = 1'b0, power_good_reset_in = 1'b1, battery_loss_reset_in = 1'b1;
	logic io_rd_hit_o, sys_addr20_o, cpu_reset_o, nmi_o, timer2_output, timer2_gate_o, speaker_o;
	logic [6:0] clock_index_o;
	logic clock_index_wr_o, external_addr20_gate_input, kbc_cpu_reset_n_i, hw_reset_o, full_reset_o;
	int n_fail = 0, samples_checked = 0;
	lss_top dut (.clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
		.io_rd_hit_o, .cpu_status_i, .cpu_status_valid_i, .cpu_addr20_i, .sys_addr20_o, .cpu_reset_o,
		.parity_err_i, .io_check_err_i, .nmi_o, .timer2_output, .timer2_gate_o, .speaker_o,
		.clock_index_o, .clock_index_wr_o, .external_addr20_gate_input, .kbc_cpu_reset_n_i,
		.power_good_reset_in, .battery_loss_reset_in, .hw_reset_o, .full_reset_o);
	lss_kbc_model kbc (.clk_i, .gate_i(timer2_gate_o), .a20_cmd_i(a20_cmd),
		.cpu_rst_cmd_i(cpu_rst_cmd), .timer2_o(timer2_output),
		.a20_o(external_addr20_gate_input), .cpu_rst_n_o(kbc_cpu_reset_n_i));
	always #5 clk_i = ~clk_i;
	// ----
	// tasks
	// ----
	task automatic tk;
		@(posedge clk_i);
		#1;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		// an idle edge first, so back-to-back calls never drop and raise the strobe at once
		tk;
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		tk;
		io_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic h);
		tk;
		io_addr_i = a;
		io_rd_i = 1'b1;
		tk;
		io_rd_i = 1'b0;
		d = io_rdata_o;
		h = io_rd_hit_o;
	endtask
	// counts cpu-only reset cycles, so a full reset does not count
	task automatic pulse;
		int n;
		n = 0;
		repeat (40) begin
			n += (cpu_reset_o === 1'b1 && hw_reset_o === 1'b0);
			tk;
		end
		chk(8'(n >= 16), 8'h01);
	endtask
	task automatic a20(input logic inner);
		for (int i = 0; i < 4; i++) begin
			{a20_cmd, cpu_addr20_i} = 2'(i);
			tk;
			chk(sys_addr20_o, cpu_addr20_i & (a20_cmd | inner));
		end
	endtask
	task automatic results;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----
	// sequence
	// ----
	initial begin
		#100us;
		n_fail++;
		results;
	end
	initial begin
		logic [7:0] d;
		logic h;
		repeat (20) tk;
		rst_i = 1'b0;
		repeat (30) tk;
		chk({nmi_o, timer2_gate_o, speaker_o, hw_reset_o, cpu_reset_o}, 8'h00);
		foreach (ROWS[i]) begin
			wr(lss_pkg::FEATURE_PORT_ADDR, ROWS[i].d);
			chk(timer2_gate_o, ROWS[i].d[0]);
			tk;
			chk(speaker_o, timer2_output & ROWS[i].d[1]);
			rd(lss_pkg::FEATURE_PORT_ADDR, d, h);
			chk(h, 1'b1);
			chk(d[4:0], ROWS[i].rb);
		end
		rd(lss_pkg::NMI_CLOCK_ADDR, d, h);
		chk({h, d[6:0]}, 8'h00);
		rd(16'h0060, d, h);
		chk(h, 1'b0);
		wr(lss_pkg::NMI_CLOCK_ADDR, 8'h85);
		chk({clock_index_wr_o, clock_index_o}, 8'h85);
		wr(lss_pkg::FEATURE_PORT_ADDR, 8'h0c);
		parity_err_i = 1'b1;
		tk;
		chk(nmi_o, 1'b0);
		wr(lss_pkg::NMI_CLOCK_ADDR, 8'h00);
		chk(nmi_o, 1'b1);
		rd(lss_pkg::FEATURE_PORT_ADDR, d, h);
		chk(d[7:5], {2'h2, timer2_output});
		io_check_err_i = 1'b1;
		rd(lss_pkg::FEATURE_PORT_ADDR, d, h);
		io_check_err_i = 1'b0;
		chk(d[7:6], 2'h3);
		wr(lss_pkg::NMI_CLOCK_ADDR, 8'h80);
		chk(nmi_o, 1'b0);
		parity_err_i = 1'b0;
		wr(lss_pkg::FEATURE_PORT_ADDR, 8'h00);
		a20(1'b0);
		wr(lss_pkg::SYS_CTRL_PORT_ADDR, 8'h02);
		a20(1'b1);
		wr(lss_pkg::SYS_CTRL_PORT_ADDR, 8'h00);
		wr(lss_pkg::CFG_INDEX_ADDR, lss_pkg::MISC1_INDEX);
		wr(lss_pkg::CFG_DATA_ADDR, 8'h02);
		a20(1'b1);
		wr(lss_pkg::CFG_DATA_ADDR, 8'h01);
		pulse;
		wr(lss_pkg::SYS_CTRL_PORT_ADDR, 8'h01);
		pulse;
		cpu_status_i = lss_pkg::SHUTDOWN_CODE;
		cpu_status_valid_i = 1'b1;
		tk;
		cpu_status_valid_i = 1'b0;
		pulse;
		cpu_rst_cmd = 1'b1;
		tk;
		cpu_rst_cmd = 1'b0;
		pulse;
		wr(lss_pkg::SYS_CTRL_PORT_ADDR, 8'h02);
		wr(lss_pkg::FEATURE_PORT_ADDR, 8'h01);
		power_good_reset_in = 1'b0;
		tk;
		chk(hw_reset_o, 1'b0);
		tk;
		chk(hw_reset_o, 1'b1);
		power_good_reset_in = 1'b1;
		repeat (30) tk;
		chk(timer2_gate_o, 1'b0);
		a20(1'b1);
		battery_loss_reset_in = 1'b0;
		repeat (3) tk;
		chk(full_reset_o, 1'b1);
		battery_loss_reset_in = 1'b1;
		repeat (30) tk;
		a20(1'b0);
		results;
	end
endmodule
bind lss_top lss_sva chk_i (.clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
	.io_rdata_o, .io_rd_hit_o, .cpu_status_i, .cpu_status_valid_i, .cpu_addr20_i, .sys_addr20_o,
	.cpu_reset_o, .nmi_o, .timer2_output, .timer2_gate_o, .speaker_o, .external_addr20_gate_input,
	.kbc_cpu_reset_n_i, .power_good_reset_in, .battery_loss_reset_in, .hw_reset_o);
